// [include/ccf_params.svh]
`ifndef CCF_PARAMS_SVH
`define CCF_PARAMS_SVH
`define CCF_CH_FIRST_IDX  8'h09
`define CCF_CH_LAST_IDX   8'h18
`define CCF_MISC_ADDR     8'h80
`define CCF_LOW_ADDR      8'h84
`define CCF_HIGH_ADDR     8'h88
`define CCF_STATUS_ADDR   8'h8C
`define CCF_IST_ADDR      8'h90
`define CCF_IMASK_ADDR    8'h94
`define CCF_ENABLE_BIT    23
`define CCF_SETUP_MSB     22
`define CCF_SETUP_LSB     20
`define CCF_SWITCH_BIT    19
`define CCF_THRES_BIT     18
`define CCF_AINP_MSB      17
`define CCF_AINP_LSB      13
`define CCF_AINM_MSB      12
`define CCF_AINM_LSB      8
`define CCF_CH0_RESET     24'h800100
`define CCF_CHN_RESET     24'h000100
`define CCF_KEEP_BIT      0
`define CCF_FIFO_BIT      1
`define CCF_PMODE_LSB     2
`define CCF_IRQ_THR_BIT   0
`define CCF_IRQ_RES_BIT   1
`define CCF_RESP_OKAY     2'h0
`define CCF_RESP_SLVERR   2'h2
`endif

// [include/ccf_pkg.sv]
package ccf_pkg;
  typedef enum logic [1:0] {
    CCF_PM_RUN,
    CCF_PM_STANDBY,
    CCF_PM_DOWN,
    CCF_PM_SPARE
  } ccf_pmode_t;

  typedef struct packed {
    logic [15:0][23:0] chan;
    logic              keep;
    logic              fifo_en;
    ccf_pmode_t        pmode;
    logic [23:0]       low;
    logic [23:0]       high;
    logic [3:0]        cur;
    logic [3:0]        stat_ch;
    logic [1:0]        ist;
    logic [1:0]        imask;
    logic              aw_ok;
    logic              w_ok;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } ccf_state_t;
endpackage

// [core/ccf_channel_config.sv]
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "ccf_params.svh"

module ccf_channel_config (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              result_valid,
  input  wire logic [23:0]       result_data,
  output logic [3:0]             active_channel,
  output logic [2:0]             setup_select,
  output logic [4:0]             positive_input_select,
  output logic [4:0]             negative_input_select,
  output ccf_pkg::ccf_pmode_t    power_mode,
  output logic                   low_side_switch_pin,
  output logic                   irq
);
  import ccf_pkg::*;

  ccf_state_t st_q;
  ccf_state_t st_d;
  logic [15:0] en_vec;
  logic [3:0]  nxt_ch;
  logic [23:0] cur_reg;
  logic        wr_fire;
  logic        rd_fire;
  logic        thr_hit;
  logic [31:0] wmask;
  logic [15:0] en_rot;

  for (genvar g = 0; g < 16; g++) begin : g_en
    assign en_vec[g] = st_q.chan[g][`CCF_ENABLE_BIT];
  end

  function automatic logic [3:0] next_enabled(input logic [15:0] en, input logic [3:0] cur);
    logic [3:0] res;
    logic       found;
    res = cur;
    found = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      if (!found && en[4'(cur + 4'(i))]) begin
        res = 4'(cur + 4'(i));
        found = 1'b1;
      end
    end
    return res;
  endfunction

  assign nxt_ch = next_enabled(en_vec, st_q.cur);
  // bit k is the enable of channel cur+1+k, wrapping; used by the sequencer skip check
  assign en_rot = 16'({en_vec, en_vec} >> (5'(st_q.cur) + 5'd1));
  assign cur_reg = st_q.chan[st_q.cur];
  assign wr_fire = st_q.aw_ok && st_q.w_ok && !st_q.bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign thr_hit = result_valid && st_q.fifo_en && cur_reg[`CCF_THRES_BIT]
                   && ((result_data < st_q.low) || (result_data > st_q.high));
  for (genvar b = 0; b < 4; b++) begin : g_strb
    assign wmask[8*b +: 8] = {8{st_q.wstrb[b]}};
  end

  always_comb begin
    logic [7:0] ridx;
    logic [7:0] widx;
    ridx = {2'h0, s_axi_araddr[7:2]};
    widx = {2'h0, st_q.awaddr[7:2]};
    st_d = st_q;
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_ok = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_ok = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (wr_fire) begin
      st_d.aw_ok = 1'b0;
      st_d.w_ok = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = `CCF_RESP_OKAY;
      if (widx >= `CCF_CH_FIRST_IDX && widx <= `CCF_CH_LAST_IDX) begin
        st_d.chan[4'(widx - `CCF_CH_FIRST_IDX)] = ((st_q.wdata[23:0] & wmask[23:0])
          | (st_q.chan[4'(widx - `CCF_CH_FIRST_IDX)] & ~wmask[23:0]));
      end else if (st_q.awaddr == `CCF_MISC_ADDR) begin
        if (st_q.wstrb[0]) begin
          st_d.keep = st_q.wdata[`CCF_KEEP_BIT];
          st_d.fifo_en = st_q.wdata[`CCF_FIFO_BIT];
          st_d.pmode = ccf_pmode_t'(st_q.wdata[`CCF_PMODE_LSB +: 2]);
        end
      end else if (st_q.awaddr == `CCF_LOW_ADDR) begin
        st_d.low = (st_q.wdata[23:0] & wmask[23:0]) | (st_q.low & ~wmask[23:0]);
      end else if (st_q.awaddr == `CCF_HIGH_ADDR) begin
        st_d.high = (st_q.wdata[23:0] & wmask[23:0]) | (st_q.high & ~wmask[23:0]);
      end else if (st_q.awaddr == `CCF_IST_ADDR) begin
        if (st_q.wstrb[0]) begin
          st_d.ist = st_q.ist & ~st_q.wdata[1:0];
        end
      end else if (st_q.awaddr == `CCF_IMASK_ADDR) begin
        if (st_q.wstrb[0]) begin
          st_d.imask = st_q.wdata[1:0];
        end
      end else if (st_q.awaddr != `CCF_STATUS_ADDR) begin
        st_d.bresp = `CCF_RESP_SLVERR;
      end
    end
    if (rd_fire) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = `CCF_RESP_OKAY;
      st_d.rdata = 32'h0;
      if (ridx >= `CCF_CH_FIRST_IDX && ridx <= `CCF_CH_LAST_IDX) begin
        st_d.rdata[23:0] = st_q.chan[4'(ridx - `CCF_CH_FIRST_IDX)];
      end else if (s_axi_araddr == `CCF_MISC_ADDR) begin
        st_d.rdata[3:0] = {st_q.pmode, st_q.fifo_en, st_q.keep};
      end else if (s_axi_araddr == `CCF_LOW_ADDR) begin
        st_d.rdata[23:0] = st_q.low;
      end else if (s_axi_araddr == `CCF_HIGH_ADDR) begin
        st_d.rdata[23:0] = st_q.high;
      end else if (s_axi_araddr == `CCF_STATUS_ADDR) begin
        st_d.rdata[3:0] = st_q.stat_ch;
      end else if (s_axi_araddr == `CCF_IST_ADDR) begin
        st_d.rdata[1:0] = st_q.ist;
      end else if (s_axi_araddr == `CCF_IMASK_ADDR) begin
        st_d.rdata[1:0] = st_q.imask;
      end else begin
        st_d.rresp = `CCF_RESP_SLVERR;
      end
    end
    // events set after the clear so a same-cycle set wins
    if (thr_hit) begin
      st_d.ist[`CCF_IRQ_THR_BIT] = 1'b1;
    end
    if (result_valid) begin
      st_d.ist[`CCF_IRQ_RES_BIT] = 1'b1;
      st_d.stat_ch = st_q.cur;
      st_d.cur = nxt_ch;
    end else if (!en_vec[st_q.cur]) begin
      st_d.cur = nxt_ch;
    end
    if (!aresetn) begin
      st_d = '0;
      for (int c = 0; c < 16; c++) begin
        st_d.chan[c] = (c == 0) ? `CCF_CH0_RESET : `CCF_CHN_RESET;
      end
      st_d.pmode = CCF_PM_RUN;
    end
  end

  always_ff @(posedge aclk) begin
    st_q <= st_d;
  end

  assign s_axi_awready = !st_q.aw_ok && !st_q.bvalid;
  assign s_axi_wready = !st_q.w_ok && !st_q.bvalid;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  assign active_channel = st_q.cur;
  assign setup_select = cur_reg[`CCF_SETUP_MSB:`CCF_SETUP_LSB];
  // codes pass unchanged; the analog mux decodes all 32 values
  assign positive_input_select = cur_reg[`CCF_AINP_MSB:`CCF_AINP_LSB];
  assign negative_input_select = cur_reg[`CCF_AINM_MSB:`CCF_AINM_LSB];
  assign power_mode = st_q.pmode;
  assign low_side_switch_pin = cur_reg[`CCF_SWITCH_BIT]
                               && (st_q.pmode != CCF_PM_DOWN)
                               && !(st_q.pmode == CCF_PM_STANDBY && !st_q.keep);
  assign irq = |(st_q.ist & st_q.imask);

  sw_down_a : assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.pmode == CCF_PM_DOWN |-> !low_side_switch_pin) else $error("switch closed in power-down");
  sw_standby_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.pmode == CCF_PM_STANDBY && !st_q.keep) |-> !low_side_switch_pin)
    else $error("switch closed in standby without keep");
  sw_follow_a : assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.pmode == CCF_PM_RUN |-> low_side_switch_pin == st_q.chan[active_channel][`CCF_SWITCH_BIT])
    else $error("switch does not follow channel bit");
  sw_open_a : assert property (@(posedge aclk) disable iff (!aresetn)
    !st_q.chan[active_channel][`CCF_SWITCH_BIT] |-> !low_side_switch_pin)
    else $error("switch closed with enable clear");
  stat_ch_a : assert property (@(posedge aclk) disable iff (!aresetn)
    result_valid |=> st_q.stat_ch == $past(st_q.cur)) else $error("status channel wrong");
  thr_set_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (result_valid && st_q.fifo_en && cur_reg[`CCF_THRES_BIT] && result_data > st_q.high)
    |=> st_q.ist[`CCF_IRQ_THR_BIT]) else $error("threshold crossing missed");
  thr_fifo_off_a : assert property (@(posedge aclk) disable iff (!aresetn)
    !st_q.fifo_en |=> !$rose(st_q.ist[`CCF_IRQ_THR_BIT])) else $error("threshold set with fifo off");

  // sequencer: lands on an enabled channel and skips none on the way up
  seq_land_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (result_valid && (|en_vec)) |=> ((($past(en_vec) >> st_q.cur) & 16'h0001) != 16'h0000))
    else $error("sequence landed on disabled channel");
  seq_skip_a : assert property (@(posedge aclk) disable iff (!aresetn)
    result_valid |=>
      ($past(en_rot) & ((16'h0001 << 4'(st_q.cur - $past(st_q.cur) - 4'h1)) - 16'h0001)) == 16'h0000)
    else $error("sequence skipped an enabled channel");
  chan_hold_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (!result_valid && en_vec[st_q.cur]) |=> st_q.cur == $past(st_q.cur))
    else $error("active channel moved without result");
  setup_sel_a : assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.chan[active_channel][`CCF_SETUP_MSB:`CCF_SETUP_LSB] inside {3'h6, 3'h7}
    |-> setup_select == st_q.chan[active_channel][`CCF_SETUP_MSB:`CCF_SETUP_LSB])
    else $error("setup select mismatch");

  // switch control per power mode
  sw_close_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.pmode == CCF_PM_RUN && cur_reg[`CCF_SWITCH_BIT]) |-> low_side_switch_pin)
    else $error("switch open with enable set in run");
  sw_keep_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q.pmode == CCF_PM_STANDBY && st_q.keep && cur_reg[`CCF_SWITCH_BIT]) |-> low_side_switch_pin)
    else $error("switch open in standby with keep");
  sw_spare_a : assert property (@(posedge aclk) disable iff (!aresetn)
    st_q.pmode == CCF_PM_SPARE |-> low_side_switch_pin == cur_reg[`CCF_SWITCH_BIT])
    else $error("spare mode not treated as run");

  // threshold and result flags
  thr_low_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (result_valid && st_q.fifo_en && cur_reg[`CCF_THRES_BIT] && result_data < st_q.low)
    |=> st_q.ist[`CCF_IRQ_THR_BIT]) else $error("low crossing missed");
  thr_range_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (result_valid && result_data >= st_q.low && result_data <= st_q.high && !st_q.ist[`CCF_IRQ_THR_BIT])
    |=> !st_q.ist[`CCF_IRQ_THR_BIT]) else $error("threshold set inside limits");
  thr_chan_off_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (result_valid && !cur_reg[`CCF_THRES_BIT] && !st_q.ist[`CCF_IRQ_THR_BIT])
    |=> !st_q.ist[`CCF_IRQ_THR_BIT]) else $error("threshold set with channel watch off");
  res_set_a : assert property (@(posedge aclk) disable iff (!aresetn)
    result_valid |=> st_q.ist[`CCF_IRQ_RES_BIT]) else $error("result flag not set");
  stat_keep_a : assert property (@(posedge aclk) disable iff (!aresetn)
    !result_valid |=> $stable(st_q.stat_ch)) else $error("status channel changed without result");
  irq_level_a : assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(st_q.ist & st_q.imask)) else $error("interrupt level wrong");

  // register bus handshake
  bhold_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid) else $error("write response dropped");
  bresp_hold_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> $stable(s_axi_bresp)) else $error("write response changed");
  rhold_a : assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_rvalid && !s_axi_rready) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped or changed");
  wr_resp_a : assert property (@(posedge aclk) disable iff (!aresetn)
    wr_fire |=> s_axi_bvalid) else $error("write response missing");
  rd_resp_a : assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire |=> s_axi_rvalid) else $error("read response missing");
  wblock_a : assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken during response");
  rblock_a : assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken during response");

  // reset state, checked one cycle after each cycle with reset sampled low
  rst_state_a : assert property (@(posedge aclk)
    !aresetn |=> active_channel == 4'h0 && !irq && !s_axi_bvalid && !s_axi_rvalid && !low_side_switch_pin)
    else $error("reset state wrong");
  rst_chan_a : assert property (@(posedge aclk)
    !aresetn |=> st_q.chan[0] == `CCF_CH0_RESET && st_q.chan[15] == `CCF_CHN_RESET)
    else $error("channel reset value wrong");
endmodule

// [tb/tb_ccf_channel_config.sv]
`timescale 1ns/1ps
`include "ccf_params.svh"

module tb_ccf_channel_config;
  import ccf_pkg::*;
  logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, result_valid, low_side_switch_pin, irq;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb, active_channel;
  logic [1:0]   bresp, rresp;
  logic [23:0]  result_data;
  logic [2:0]   setup_select;
  logic [4:0]   positive_input_select, negative_input_select;
  ccf_pmode_t   power_mode;
  int           failures, total_checks;
  logic [7:0]   misc_val [5] = '{8'h0A, 8'h06, 8'h07, 8'h0E, 8'h02};
  logic [2:0]   mode_exp [5] = '{3'b100, 3'b010, 3'b011, 3'b111, 3'b001};

  ccf_channel_config u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .result_valid(result_valid),
    .result_data(result_data), .active_channel(active_channel), .setup_select(setup_select),
    .positive_input_select(positive_input_select), .negative_input_select(negative_input_select),
    .power_mode(power_mode), .low_side_switch_pin(low_side_switch_pin), .irq(irq)
  );

  always #5 aclk = ~aclk;

  task automatic end_of_test();
    if (failures == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] ch_addr(input int m);
    return 8'((`CCF_CH_FIRST_IDX + m) * 4);
  endfunction

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_hit, w_hit, b_hit;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hit = 1'b0;
    while (!b_hit) begin
      @(negedge aclk);
      aw_hit = awvalid && (awready === 1'b1);
      w_hit = wvalid && (wready === 1'b1);
      b_hit = bvalid === 1'b1;
      if (b_hit) check(32'(bresp), 32'(er));
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (b_hit) bready <= 1'b0;
    end
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_hit, r_hit;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hit = 1'b0;
    while (!r_hit) begin
      @(negedge aclk);
      ar_hit = arvalid && (arready === 1'b1);
      r_hit = rvalid === 1'b1;
      if (r_hit) check(32'(rresp), 32'(er));
      if (r_hit && er == `CCF_RESP_OKAY) check(rdata, ed);
      @(posedge aclk);
      if (ar_hit) arvalid <= 1'b0;
      if (r_hit) rready <= 1'b0;
    end
  endtask

  task automatic result(input logic [23:0] d);
    @(posedge aclk);
    result_valid <= 1'b1;
    result_data <= d;
    @(posedge aclk);
    result_valid <= 1'b0;
  endtask

  // active channel, setup, positive input, negative input and switch, sampled away from the edge
  task automatic outs(input logic [3:0] ch, input logic [2:0] su, input logic [4:0] ps, input logic [4:0] nm,
                      input logic sw);
    @(negedge aclk);
    check(32'({active_channel, setup_select, positive_input_select, negative_input_select, low_side_switch_pin}),
          32'({ch, su, ps, nm, sw}));
  endtask

  initial begin
    #20000;
    failures++;
    end_of_test();
  end

  initial begin
    aclk = 0; aresetn = 0; awaddr = '0; awvalid = 0; wdata = '0; wstrb = '0; wvalid = 0;
    bready = 0; araddr = '0; arvalid = 0; rready = 0; result_valid = 0; result_data = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(ch_addr(0), 32'h00800100, `CCF_RESP_OKAY);
    axi_read(ch_addr(15), 32'h00000100, `CCF_RESP_OKAY);
    axi_read(8'hFC, 32'h0, `CCF_RESP_SLVERR);
    axi_write(8'hFC, 32'h1, `CCF_RESP_SLVERR);
    axi_write(`CCF_LOW_ADDR, 32'h10, `CCF_RESP_OKAY);
    axi_write(`CCF_HIGH_ADDR, 32'h100, `CCF_RESP_OKAY);
    axi_write(`CCF_IMASK_ADDR, 32'h3, `CCF_RESP_OKAY);
    axi_write(ch_addr(0), 32'h00ED6100, `CCF_RESP_OKAY);
    axi_write(ch_addr(3), 32'h00F0A200, `CCF_RESP_OKAY);
    axi_read(ch_addr(3), 32'h00F0A200, `CCF_RESP_OKAY);
    outs(4'd0, 3'd6, 5'd11, 5'd1, 1'b1);
    result(24'h000200);
    outs(4'd3, 3'd7, 5'd5, 5'd2, 1'b0);
    axi_read(`CCF_IST_ADDR, 32'h2, `CCF_RESP_OKAY);
    @(negedge aclk);
    check(32'(irq), 32'h1);
    result(24'h000200);
    outs(4'd0, 3'd6, 5'd11, 5'd1, 1'b1);
    axi_read(`CCF_STATUS_ADDR, 32'h3, `CCF_RESP_OKAY);
    axi_write(`CCF_MISC_ADDR, 32'h2, `CCF_RESP_OKAY);
    axi_write(`CCF_IST_ADDR, 32'h3, `CCF_RESP_OKAY);
    axi_read(`CCF_IST_ADDR, 32'h0, `CCF_RESP_OKAY);
    @(negedge aclk);
    check(32'(irq), 32'h0);
    result(24'h000005);
    axi_read(`CCF_IST_ADDR, 32'h3, `CCF_RESP_OKAY);
    axi_write(`CCF_IMASK_ADDR, 32'h1, `CCF_RESP_OKAY);
    axi_write(`CCF_IST_ADDR, 32'h2, `CCF_RESP_OKAY);
    @(negedge aclk);
    check(32'(irq), 32'h1);
    axi_write(`CCF_IST_ADDR, 32'h1, `CCF_RESP_OKAY);
    @(negedge aclk);
    check(32'(irq), 32'h0);
    result(24'h000005);
    outs(4'd0, 3'd6, 5'd11, 5'd1, 1'b1);
    for (int i = 0; i < 5; i++) begin
      axi_write(`CCF_MISC_ADDR, 32'(misc_val[i]), `CCF_RESP_OKAY);
      @(negedge aclk);
      check(32'({power_mode, low_side_switch_pin}), 32'(mode_exp[i]));
    end
    axi_write(ch_addr(0), 32'h00EE0100, `CCF_RESP_OKAY);
    outs(4'd0, 3'd6, 5'd16, 5'd1, 1'b1);
    end_of_test();
  end
endmodule
